/* File: hdl/amc_irq.sv */
/*
  Interrupt mask, flags, global enable and service tracking.
  Assumes event pulses and core strobes on clk_sys, one cycle each.
*/
`timescale 1ns/1ps
`include "amc_params.svh"

module amc_irq (
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire logic            clk_en,
  input  wire amc_pkg::amc_byte_t set_pulse,
  input  wire logic            mask_wr,
  input  wire logic            flag_wr,
  input  wire amc_pkg::amc_byte_t wdata,
  input  wire logic            sleep_mode,
  input  wire logic            wake_by_other,
  input  wire logic            irq_take,
  input  wire logic            irq_return,
  output amc_pkg::amc_byte_t   mask_rd,
  output amc_pkg::amc_byte_t   flag_rd,
  output logic                 irq_req,
  output logic                 in_service
);

  amc_pkg::amc_byte_t mask_q, mask_d;
  amc_pkg::amc_byte_t flag_q, flag_d;
  amc_pkg::amc_byte_t slept_q, slept_d;
  logic               gie_q, gie_d;
  amc_pkg::amc_svc_e  svc_q, svc_d;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    mask_d  = mask_q;
    gie_d   = gie_q;
    flag_d  = flag_q;
    svc_d   = svc_q;
    if (mask_wr)
    begin
      mask_d = wdata & `AMC_IRQ_IMPL;
      gie_d  = wdata[`AMC_IRQ_GIE];
    end
    // hardware strobes override a software write of the same cycle
    if (irq_take)
      gie_d = 1'b0;
    else if (irq_return)
      gie_d = 1'b1;
    if (flag_wr)
      flag_d = flag_q & wdata;
    flag_d = (flag_d | set_pulse) & `AMC_IRQ_IMPL;
    // events seen while asleep are remembered until sleep ends
    slept_d = sleep_mode ? (slept_q | set_pulse) : `AMC_RST_ZERO;
    if (wake_by_other)
      flag_d = flag_d & ~(slept_q | slept_d);
    case (svc_q)
      amc_pkg::AMC_SVC_IDLE:
        if (irq_take)
          svc_d = amc_pkg::AMC_SVC_BUSY;
      amc_pkg::AMC_SVC_BUSY:
        if (irq_return)
          svc_d = amc_pkg::AMC_SVC_IDLE;
      default:
        svc_d = amc_pkg::AMC_SVC_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_q  <= `AMC_RST_ZERO;
      flag_q  <= `AMC_RST_ZERO;
      slept_q <= `AMC_RST_ZERO;
      gie_q   <= 1'b0;
      svc_q   <= amc_pkg::AMC_SVC_IDLE;
    end
    else if (clk_en)
    begin
      mask_q  <= mask_d;
      flag_q  <= flag_d;
      slept_q <= slept_d;
      gie_q   <= gie_d;
      svc_q   <= svc_d;
    end
  end

  assign mask_rd    = mask_q | {gie_q, 7'h00};
  assign flag_rd    = flag_q;
  assign in_service = (svc_q == amc_pkg::AMC_SVC_BUSY);
  // requests stay held during sleep and during a running routine
  assign irq_req    = gie_q && !sleep_mode && !in_service
                      && |(flag_q & mask_q);

endmodule // amc_irq

/* File: hdl/amc_params.svh */
/*
  Offsets, field positions, reset values and widths of the
  advanced-mode control register bank.
  Assumes inclusion by bare name from the bank's design files.
*/
// Function
// - 7-bit operand addresses 00h-40h directly
// - registers at 20h, 21h, 22h, 40h
// - 24 general bytes at 28h-3Fh
// - pull-up only when enabled and pin input
// - software watchdog gated by configuration enable
// - wake-up register bit 6 enables wake-up
// - bit 5 selects clock pin, else I/O
// - wake-up register resets zero, bits 4-2 zero
// - bit 1 makes bit-5 pin interrupt source
// - bit 0 makes bit-0 pin interrupt source
// - service only awake, sleep interrupts held
// - non-wake-pin exits discard sleep interrupts
// - three timer and two pin sources
// - no nesting during service routine
// - taking clears global enable, return sets it
// - flags set by hardware, software only clears
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

`define AMC_ADDR_PULLUP  7'h20
`define AMC_ADDR_MASK    7'h21
`define AMC_ADDR_FLAGS   7'h22
`define AMC_ADDR_WDSEL   7'h23
`define AMC_ADDR_T1CTL   7'h24
`define AMC_ADDR_T2CTL   7'h25
`define AMC_ADDR_T1RLD   7'h26
`define AMC_ADDR_T2RLD   7'h27
`define AMC_ADDR_GP_LO   7'h28
`define AMC_ADDR_GP_HI   7'h3f
`define AMC_ADDR_WAKE    7'h40
`define AMC_GP_DEPTH     24

`define AMC_WAKE_SWD     7
`define AMC_WAKE_EXTWK   6
`define AMC_WAKE_CLKSEL  5
`define AMC_WAKE_SEL1    1
`define AMC_WAKE_SEL0    0
`define AMC_WAKE_IMPL    8'he3

`define AMC_IRQ_GIE      7
`define AMC_IRQ_TIM2     5
`define AMC_IRQ_TIM1     4
`define AMC_IRQ_EXT1     2
`define AMC_IRQ_EXT0     1
`define AMC_IRQ_TIM0     0
`define AMC_IRQ_IMPL     8'h37

`define AMC_RST_ZERO     8'h00
`define AMC_RST_WDSEL    8'h03

`endif

/* File: hdl/amc_pkg.sv */
/*
  Types shared by the advanced-mode control register bank.
  Assumes nothing of its surroundings.
*/
package amc_pkg;
  typedef enum logic [0:0] {
    AMC_SVC_IDLE = 1'b0,
    AMC_SVC_BUSY = 1'b1
  } amc_svc_e;

  typedef logic [7:0] amc_byte_t;
endpackage

/* File: hdl/amc_regs.sv */
/*
  Advanced-mode control register bank: direct 7-bit data memory
  decode for 20h-40h, general bytes, port B pull-ups, wake-up
  control and the interrupt block.
  Assumes the core drives the memory strobes and interrupt strobes
  on clk_sys; pin inputs are asynchronous.
*/
`timescale 1ns/1ps
`include "amc_params.svh"

module amc_regs (
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire logic            clk_en,
  input  wire logic [6:0]      mem_addr,
  input  wire logic            mem_wr,
  input  wire logic            mem_rd,
  input  wire logic [7:0]      mem_wdata,
  output logic [7:0]           mem_rdata,
  output logic                 mem_hit,
  input  wire logic            config_watchdog_enable,
  input  wire logic [7:0]      portb_dir_in,
  output logic [7:0]           portb_pullup,
  input  wire logic            porta_bit0_pin,
  input  wire logic            porta_bit5_pin,
  input  wire logic            timer_zero_ovf,
  input  wire logic            timer_one_ovf,
  input  wire logic            timer_two_ovf,
  input  wire logic            sleep_mode,
  input  wire logic            wake_by_other,
  input  wire logic            irq_take,
  input  wire logic            irq_return,
  output logic                 irq_req,
  output logic                 in_service,
  output logic                 watchdog_enable,
  output logic                 external_wakeup_enable,
  output logic                 ext_clock_pin_select,
  output logic                 ext_irq_select_one,
  output logic                 ext_irq_select_zero,
  output logic [7:0]           watchdog_period_select,
  output logic [7:0]           timer_one_control,
  output logic [7:0]           timer_two_control,
  output logic [7:0]           timer_one_reload,
  output logic [7:0]           timer_two_reload
);

  // --------------------------------------------------------------
  // address helpers
  // --------------------------------------------------------------
  function automatic logic is_gp(input logic [6:0] a);
    is_gp = (a >= `AMC_ADDR_GP_LO) && (a <= `AMC_ADDR_GP_HI);
  endfunction

  function automatic logic [4:0] gp_index(input logic [6:0] a);
    logic [6:0] off;
    off      = a - `AMC_ADDR_GP_LO;
    gp_index = off[4:0];
  endfunction

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  amc_pkg::amc_byte_t gp_mem [`AMC_GP_DEPTH];
  amc_pkg::amc_byte_t pue_q, pue_d;
  amc_pkg::amc_byte_t wake_q, wake_d;
  amc_pkg::amc_byte_t wds_q, wds_d;
  amc_pkg::amc_byte_t t1c_q, t1c_d;
  amc_pkg::amc_byte_t t2c_q, t2c_d;
  amc_pkg::amc_byte_t t1r_q, t1r_d;
  amc_pkg::amc_byte_t t2r_q, t2r_d;
  amc_pkg::amc_byte_t rdata_q, rdata_d;
  amc_pkg::amc_byte_t pull_q, pull_d;
  amc_pkg::amc_byte_t mask_rd;
  amc_pkg::amc_byte_t flag_rd;
  amc_pkg::amc_byte_t set_pulse;
  amc_pkg::amc_byte_t rd_mux;
  logic               wr_mask;
  logic               wr_flag;
  logic               gp_wr;
  logic [4:0]         gp_idx;
  logic [1:0]         p0_sync_q, p0_sync_d;
  logic [1:0]         p5_sync_q, p5_sync_d;
  logic               p0_prev_q, p5_prev_q;
  logic               ext0_edge;
  logic               ext1_edge;

  // --------------------------------------------------------------
  // direct address decode
  // --------------------------------------------------------------
  always_comb
  begin
    pue_d   = pue_q;
    wake_d  = wake_q;
    wds_d   = wds_q;
    t1c_d   = t1c_q;
    t2c_d   = t2c_q;
    t1r_d   = t1r_q;
    t2r_d   = t2r_q;
    wr_mask = 1'b0;
    wr_flag = 1'b0;
    gp_wr   = 1'b0;
    rd_mux  = `AMC_RST_ZERO;
    mem_hit = 1'b1;
    // the whole operand is the address, no bank bits take part
    if (mem_addr == `AMC_ADDR_PULLUP)
    begin
      rd_mux = pue_q;
      if (mem_wr)
        pue_d = mem_wdata;
    end
    else if (mem_addr == `AMC_ADDR_MASK)
    begin
      rd_mux  = mask_rd;
      wr_mask = mem_wr;
    end
    else if (mem_addr == `AMC_ADDR_FLAGS)
    begin
      rd_mux  = flag_rd;
      wr_flag = mem_wr;
    end
    else if (mem_addr == `AMC_ADDR_WDSEL)
    begin
      rd_mux = wds_q;
      if (mem_wr)
        wds_d = mem_wdata;
    end
    else if (mem_addr == `AMC_ADDR_T1CTL)
    begin
      rd_mux = t1c_q;
      if (mem_wr)
        t1c_d = mem_wdata;
    end
    else if (mem_addr == `AMC_ADDR_T2CTL)
    begin
      rd_mux = t2c_q;
      if (mem_wr)
        t2c_d = mem_wdata;
    end
    else if (mem_addr == `AMC_ADDR_T1RLD)
    begin
      rd_mux = t1r_q;
      if (mem_wr)
        t1r_d = mem_wdata;
    end
    else if (mem_addr == `AMC_ADDR_T2RLD)
    begin
      rd_mux = t2r_q;
      if (mem_wr)
        t2r_d = mem_wdata;
    end
    else if (is_gp(mem_addr))
    begin
      rd_mux = gp_mem[gp_index(mem_addr)];
      gp_wr  = mem_wr;
    end
    else if (mem_addr == `AMC_ADDR_WAKE)
    begin
      rd_mux = wake_q;
      if (mem_wr)
        wake_d = mem_wdata & `AMC_WAKE_IMPL;
    end
    else
      mem_hit = 1'b0; // 00h-1Fh belong to the core, above 40h unused
  end

  assign gp_idx = gp_index(mem_addr);

  // read data is captured so the core sees it from a flop
  always_comb
  begin
    rdata_d = mem_rd ? rd_mux : rdata_q;
  end

  // --------------------------------------------------------------
  // pins and interrupt sources
  // --------------------------------------------------------------
  always_comb
  begin
    p0_sync_d = {p0_sync_q[0], porta_bit0_pin};
    p5_sync_d = {p5_sync_q[0], porta_bit5_pin};
    // an output pin never gets the pull-up, whatever the enable
    pull_d    = pue_q & portb_dir_in;
  end

  // reset/interrupt pins are active low: a falling edge requests
  assign ext0_edge = p0_prev_q && !p0_sync_q[1]
                     && wake_q[`AMC_WAKE_SEL0];
  assign ext1_edge = p5_prev_q && !p5_sync_q[1]
                     && wake_q[`AMC_WAKE_SEL1];

  always_comb
  begin
    set_pulse = `AMC_RST_ZERO;
    set_pulse[`AMC_IRQ_TIM0] = timer_zero_ovf;
    set_pulse[`AMC_IRQ_TIM1] = timer_one_ovf;
    set_pulse[`AMC_IRQ_TIM2] = timer_two_ovf;
    set_pulse[`AMC_IRQ_EXT0] = ext0_edge;
    set_pulse[`AMC_IRQ_EXT1] = ext1_edge;
  end

  amc_irq u_irq (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .clk_en        (clk_en),
    .set_pulse     (set_pulse),
    .mask_wr       (wr_mask),
    .flag_wr       (wr_flag),
    .wdata         (mem_wdata),
    .sleep_mode    (sleep_mode),
    .wake_by_other (wake_by_other),
    .irq_take      (irq_take),
    .irq_return    (irq_return),
    .mask_rd       (mask_rd),
    .flag_rd       (flag_rd),
    .irq_req       (irq_req),
    .in_service    (in_service)
  );

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pue_q     <= `AMC_RST_ZERO;
      wake_q    <= `AMC_RST_ZERO;
      wds_q     <= `AMC_RST_WDSEL;
      t1c_q     <= `AMC_RST_ZERO;
      t2c_q     <= `AMC_RST_ZERO;
      t1r_q     <= `AMC_RST_ZERO;
      t2r_q     <= `AMC_RST_ZERO;
      rdata_q   <= `AMC_RST_ZERO;
      pull_q    <= `AMC_RST_ZERO;
      p0_sync_q <= 2'h3;
      p5_sync_q <= 2'h3;
      p0_prev_q <= 1'b1;
      p5_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      pue_q     <= pue_d;
      wake_q    <= wake_d;
      wds_q     <= wds_d;
      t1c_q     <= t1c_d;
      t2c_q     <= t2c_d;
      t1r_q     <= t1r_d;
      t2r_q     <= t2r_d;
      rdata_q   <= rdata_d;
      pull_q    <= pull_d;
      p0_sync_q <= p0_sync_d;
      p5_sync_q <= p5_sync_d;
      p0_prev_q <= p0_sync_q[1];
      p5_prev_q <= p5_sync_q[1];
    end
  end

  // general bytes carry no reset, like plain data memory
  always_ff @(posedge clk_sys)
  begin
    if (clk_en && gp_wr)
      gp_mem[gp_idx] <= mem_wdata;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign mem_rdata              = rdata_q;
  assign portb_pullup           = pull_q;
  // configuration enable gates the software bit: both must be set
  assign watchdog_enable        = config_watchdog_enable
                                  && wake_q[`AMC_WAKE_SWD];
  assign external_wakeup_enable = wake_q[`AMC_WAKE_EXTWK];
  assign ext_clock_pin_select   = wake_q[`AMC_WAKE_CLKSEL];
  assign ext_irq_select_one     = wake_q[`AMC_WAKE_SEL1];
  assign ext_irq_select_zero    = wake_q[`AMC_WAKE_SEL0];
  assign watchdog_period_select = wds_q;
  assign timer_one_control      = t1c_q;
  assign timer_two_control      = t2c_q;
  assign timer_one_reload       = t1r_q;
  assign timer_two_reload       = t2r_q;

endmodule // amc_regs

/* File: verification/amc_regs_checker.sv */
/*
  Port-level checks for the advanced-mode control register bank.
  Assumes binding into amc_regs, one clock clk_sys, reset rstn.
*/
`timescale 1ns/1ps

module amc_regs_checker (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic [6:0] mem_addr,
  input wire logic       mem_wr,
  input wire logic       mem_rd,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic       mem_hit,
  input wire logic       config_watchdog_enable,
  input wire logic [7:0] portb_dir_in,
  input wire logic [7:0] portb_pullup,
  input wire logic       sleep_mode,
  input wire logic       irq_take,
  input wire logic       irq_return,
  input wire logic       irq_req,
  input wire logic       in_service,
  input wire logic       watchdog_enable,
  input wire logic       external_wakeup_enable,
  input wire logic       ext_clock_pin_select,
  input wire logic       ext_irq_select_one,
  input wire logic       ext_irq_select_zero
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_wake_wr;
    clk_en && mem_wr && mem_addr == 7'h40;
  endsequence
  sequence s_take;
    clk_en && irq_take;
  endsequence

  property p_hit;
    mem_hit == (mem_addr >= 7'h20 && mem_addr <= 7'h40);
  endproperty
  property p_unmapped;
    clk_en && mem_rd && !mem_hit |=> mem_rdata == 8'h00;
  endproperty
  property p_wake_rd;
    clk_en && mem_rd && mem_addr == 7'h40 |=> mem_rdata[4:2] == 3'h0;
  endproperty
  property p_wake_wr;
    s_wake_wr |=> ($past(mem_wdata) & 8'h63) == {1'b0,
      external_wakeup_enable, ext_clock_pin_select, 3'h0,
      ext_irq_select_one, ext_irq_select_zero};
  endproperty
  property p_wdog;
    watchdog_enable |-> config_watchdog_enable;
  endproperty
  property p_pull;
    $past(clk_en) |-> (portb_pullup & ~$past(portb_dir_in)) == 8'h00;
  endproperty
  property p_take;
    s_take |=> in_service && !irq_req;
  endproperty
  property p_nest;
    in_service |-> !irq_req;
  endproperty
  property p_sleep;
    sleep_mode |-> !irq_req;
  endproperty

  a_hit: assert property (p_hit)
    else $error("bank decode wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_wake_rd: assert property (p_wake_rd)
    else $error("wake reserved bits not zero");
  a_wake_wr: assert property (p_wake_wr)
    else $error("wake selects do not follow write");
  a_wdog: assert property (p_wdog)
    else $error("watchdog on without config");
  a_pull: assert property (p_pull)
    else $error("pull-up on output pin");
  a_take: assert property (p_take)
    else $error("take did not start service");
  a_nest: assert property (p_nest)
    else $error("request during service");
  a_sleep: assert property (p_sleep)
    else $error("request during sleep");
endmodule // amc_regs_checker

bind amc_regs amc_regs_checker u_chk (
  .clk_sys, .rstn, .clk_en, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
  .mem_rdata, .mem_hit, .config_watchdog_enable, .portb_dir_in,
  .portb_pullup, .sleep_mode, .irq_take, .irq_return, .irq_req,
  .in_service, .watchdog_enable, .external_wakeup_enable,
  .ext_clock_pin_select, .ext_irq_select_one, .ext_irq_select_zero
);

/* File: verification/amc_regs_test.sv */
/*
  Self-checking bench for the advanced-mode control register bank.
  Assumes amc_regs and its bound checker are compiled before it.
*/
`timescale 1ns/1ps

module amc_regs_test;
  logic       clk_sys, rstn, clk_en, mem_wr, mem_rd, mem_hit, irq_req;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, portb_dir_in, portb_pullup;
  logic       config_watchdog_enable, porta_bit0_pin, porta_bit5_pin;
  logic       timer_zero_ovf, timer_one_ovf, timer_two_ovf, sleep_mode;
  logic       wake_by_other, irq_take, irq_return, in_service;
  logic       watchdog_enable, external_wakeup_enable, ext_clock_pin_select;
  logic       ext_irq_select_one, ext_irq_select_zero;
  logic [7:0] watchdog_period_select, timer_one_control, timer_two_control;
  logic [7:0] timer_one_reload, timer_two_reload;
  int         err_total, check_count;

  amc_regs dut (
    .clk_sys, .rstn, .clk_en, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
    .mem_rdata, .mem_hit, .config_watchdog_enable, .portb_dir_in,
    .portb_pullup, .porta_bit0_pin, .porta_bit5_pin, .timer_zero_ovf,
    .timer_one_ovf, .timer_two_ovf, .sleep_mode, .wake_by_other,
    .irq_take, .irq_return, .irq_req, .in_service, .watchdog_enable,
    .external_wakeup_enable, .ext_clock_pin_select, .ext_irq_select_one,
    .ext_irq_select_zero, .watchdog_period_select, .timer_one_control,
    .timer_two_control, .timer_one_reload, .timer_two_reload
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // drives land 2 ns after the edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  // leading tick keeps a strobe from being dropped and raised at once
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    tick(1);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    tick(1);
    mem_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    tick(1);
    mem_addr = a;
    mem_rd = 1'b1;
    tick(1);
    mem_rd = 1'b0;
    chk("mem_rdata", exp, mem_rdata);
  endtask

  function automatic logic [7:0] wk();
    return {4'h0, external_wakeup_enable, ext_clock_pin_select,
            ext_irq_select_one, ext_irq_select_zero};
  endfunction

  task automatic wait_req();
    for (int i = 0; i < 10 && irq_req !== 1'b1; i++)
      tick(1);
    chk("irq_req", 8'h01, {7'h0, irq_req});
    if (irq_req !== 1'b1)
      close_out();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(7'h40, 8'h00);
    chk("wake outputs", 8'h00, wk());
    chk("watchdog_period_select", 8'h03, watchdog_period_select);
    for (int a = 8'h20; a < 8'h28; a++)
      rd(a[6:0], (a == 8'h23) ? 8'h03 : 8'h00);
  endtask

  task automatic t_map();
    logic [6:0] probe [4] = '{7'h1f, 7'h20, 7'h40, 7'h41};
    for (int a = 8'h23; a < 8'h40; a++)
      wr(a[6:0], a[7:0] ^ 8'h96);
    for (int a = 8'h23; a < 8'h40; a++)
      rd(a[6:0], a[7:0] ^ 8'h96);
    chk("timer_two_reload", 8'hb1, timer_two_reload);
    chk("watchdog_period_select", 8'hb5, watchdog_period_select);
    chk("timer_one_control", 8'hb2, timer_one_control);
    chk("timer_two_control", 8'hb3, timer_two_control);
    chk("timer_one_reload", 8'hb0, timer_one_reload);
    wr(7'h41, 8'hff);
    rd(7'h41, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      mem_addr = probe[i];
      tick(1);
      chk("mem_hit", {7'h0, i == 1 || i == 2}, {7'h0, mem_hit});
    end
    // frozen clock enable must not take the write
    clk_en = 1'b0;
    wr(7'h30, 8'h00);
    clk_en = 1'b1;
    rd(7'h30, 8'ha6);
  endtask

  task automatic t_pull();
    portb_dir_in = 8'h0f;
    wr(7'h20, 8'ha5);
    tick(1);
    chk("portb_pullup", 8'h05, portb_pullup);
    portb_dir_in = 8'hf0;
    tick(1);
    chk("portb_pullup", 8'ha0, portb_pullup);
  endtask

  task automatic t_wake();
    config_watchdog_enable = 1'b0;
    wr(7'h40, 8'hff);
    rd(7'h40, 8'he3);
    chk("wake outputs", 8'h0f, wk());
    chk("watchdog_enable", 8'h00, {7'h0, watchdog_enable});
    config_watchdog_enable = 1'b1;
    tick(1);
    chk("watchdog_enable", 8'h01, {7'h0, watchdog_enable});
    wr(7'h40, 8'h42);
    chk("wake outputs", 8'h0a, wk());
    chk("watchdog_enable", 8'h00, {7'h0, watchdog_enable});
  endtask

  task automatic t_irq();
    wr(7'h21, 8'hb1);
    timer_zero_ovf = 1'b1;
    tick(1);
    timer_zero_ovf = 1'b0;
    chk("irq_req", 8'h01, {7'h0, irq_req});
    irq_take = 1'b1;
    tick(1);
    irq_take = 1'b0;
    chk("in_service", 8'h01, {7'h0, in_service});
    rd(7'h21, 8'h31);
    timer_one_ovf = 1'b1;
    tick(1);
    timer_one_ovf = 1'b0;
    // enable forced back on in service: still no nested request
    wr(7'h21, 8'hb1);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    rd(7'h22, 8'h11);
    irq_return = 1'b1;
    tick(1);
    irq_return = 1'b0;
    chk("irq_req", 8'h01, {7'h0, irq_req});
    wr(7'h22, 8'hff);
    rd(7'h22, 8'h11);
    wr(7'h22, 8'h00);
    rd(7'h22, 8'h00);
  endtask

  task automatic t_sleep();
    sleep_mode = 1'b1;
    timer_two_ovf = 1'b1;
    tick(1);
    timer_two_ovf = 1'b0;
    tick(2);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    sleep_mode = 1'b0;
    tick(1);
    chk("irq_req", 8'h01, {7'h0, irq_req});
    wr(7'h22, 8'h00);
    sleep_mode = 1'b1;
    timer_two_ovf = 1'b1;
    tick(1);
    timer_two_ovf = 1'b0;
    wake_by_other = 1'b1;
    tick(1);
    wake_by_other = 1'b0;
    sleep_mode = 1'b0;
    rd(7'h22, 8'h00);
    chk("irq_req", 8'h00, {7'h0, irq_req});
  endtask

  task automatic t_pin();
    wr(7'h21, 8'h86);
    wr(7'h40, 8'h01);
    porta_bit5_pin = 1'b0;
    tick(6);
    rd(7'h22, 8'h00);
    porta_bit0_pin = 1'b0;
    wait_req();
    rd(7'h22, 8'h02);
    wr(7'h22, 8'h00);
    wr(7'h40, 8'h02);
    porta_bit5_pin = 1'b1;
    tick(4);
    porta_bit5_pin = 1'b0;
    wait_req();
    rd(7'h22, 8'h04);
  endtask

  // reset in mid-run must wipe wake selects and pending requests
  task automatic t_rerun();
    rstn = 1'b0;
    tick(2);
    chk("wake outputs", 8'h00, wk());
    chk("portb_pullup", 8'h00, portb_pullup);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    rstn = 1'b1;
    rd(7'h40, 8'h00);
    rd(7'h22, 8'h00);
    chk("watchdog_period_select", 8'h03, watchdog_period_select);
  endtask

  initial
  begin
    err_total = 0;
    check_count = 0;
    {rstn, mem_wr, mem_rd, mem_addr, mem_wdata} = '0;
    {config_watchdog_enable, timer_zero_ovf, timer_one_ovf} = '0;
    {timer_two_ovf, sleep_mode, wake_by_other, irq_take, irq_return} = '0;
    clk_en = 1'b1;
    porta_bit0_pin = 1'b1;
    porta_bit5_pin = 1'b1;
    portb_dir_in = 8'hff;
    tick(12);
    rstn = 1'b1;
    t_reset();
    t_map();
    t_pull();
    t_wake();
    t_irq();
    t_sleep();
    t_pin();
    t_rerun();
    close_out();
  end
endmodule // amc_regs_test
